// >>> hw/cicomb_regs.svh
// register offsets, field positions, reset values and counts of the interrupt combiner
`ifndef CICOMB_REGS_SVH
`define CICOMB_REGS_SVH
`define CICOMB_NSRC          8
`define CICOMB_ADDR_W        4
`define CICOMB_OFS_STATUS    4'h0
`define CICOMB_OFS_ENABLE    4'h1
`define CICOMB_OFS_ROUTE     4'h2
`define CICOMB_OFS_VSIZE     4'h3
`define CICOMB_OFS_ACTIVE    4'h4
`define CICOMB_OFS_RAW       4'h5
`define CICOMB_OFS_IRQSTAT   4'h6
`define CICOMB_OFS_IRQMASK   4'h7
`define CICOMB_OFS_CHIPSIG   4'h8
`define CICOMB_OFS_CHIPCLR   4'h9
`define CICOMB_VSIZE_W       2
`define CICOMB_VSIZE_RST     2'h0
`define CICOMB_VSIZE_NOMINAL 2'h2
`define CICOMB_ENABLE_RST    8'h00
`define CICOMB_ROUTE_RST     8'h00
`define CICOMB_IRQ_FIQ_BIT   0
`define CICOMB_IRQ_IRQ_BIT   1
`endif

// >>> hw/cicomb_pkg.sv
// types of the interrupt combiner
package cicomb_pkg;
  typedef enum logic [1:0] {
    CICOMB_VS_1B,
    CICOMB_VS_2B,
    CICOMB_VS_4B,
    CICOMB_VS_8B
  } cicomb_vsize_e;
  typedef logic [7:0] cicomb_src_t;
endpackage

// >>> hw/cicomb_pulse_det.sv
// pulse capture of one source: sync and assertion-to-pulse, repeating while level stays high
`timescale 1ns/1ps
`default_nettype none
module cicomb_pulse_det (
  input  wire logic ref_clk_in,
  input  wire logic srst_in,
  input  wire logic src_in,
  output logic      pulse_out,
  output logic      level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } cicomb_det_s;
  cicomb_det_s st_q;
  cicomb_det_s st_d;
  always_comb begin
    st_d    = st_q;
    st_d.s1 = src_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  // any high sample counts as a new pulse occurrence
  assign pulse_out = st_q.s2;
  assign level_out = st_q.s3;
endmodule // cicomb_pulse_det
`default_nettype wire

// >>> hw/cicomb_top.sv
// interrupt combiner: per-source flags routed to fast and normal request lines
//
// How it works
// - vector size resets to one byte per entry, not four, until written.
// - enabled sources combined and routed to fast and normal request outputs.
// - every high captured input sample is treated as a pulse event.
// - a held level source is detected again every cycle.
// - one status flag per source, no occurrence counter.
// - a flag stays set until software clears it here.
// - clearing a flag while the level still stands sets it again.
// - clearing the chip-signal source's status flag alone does not drop it; CHIPCLR must clear the chip flag first.
`timescale 1ns/1ps
`default_nettype none
`include "cicomb_regs.svh"
module cicomb_top
  import cicomb_pkg::*;
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      srst_in,
  input  wire logic [`CICOMB_ADDR_W-1:0] addr_in,
  input  wire logic [31:0]               wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  input  wire logic [`CICOMB_NSRC-1:0]   sys_int_in,
  input  wire logic [`CICOMB_NSRC-1:0]   chip_signal_set_in,
  output logic      [31:0]               rdata_out,
  output logic                           fast_interrupt_request_out,
  output logic                           normal_interrupt_request_out,
  output logic      [`CICOMB_NSRC-1:0]   chip_signal_interrupt_out,
  output logic      [7:0]                vector_entry_bytes_out,
  output logic                           irq_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cicomb_src_t   flag;
    cicomb_src_t   enable;
    cicomb_src_t   route;
    cicomb_vsize_e vsize;
    cicomb_src_t   chip_flag;
    logic [1:0]    istat;
    logic [1:0]    imask;
    logic          fast_interrupt_request;
    logic          nirq;
    logic [31:0]   rdata;
  } cicomb_top_s;
  cicomb_top_s st_q;
  cicomb_top_s st_d;
  cicomb_src_t src_mix;
  cicomb_src_t det_pulse;
  cicomb_src_t det_level;
  cicomb_src_t clr_mask;
  cicomb_src_t chip_clr_mask;
  logic        wr_status;
  logic        wr_chipclr;
  // ----------------------------------------------------------------
  // source capture
  // ----------------------------------------------------------------
  // chip-signal levels join the external sources on the same lines
  assign src_mix = sys_int_in | st_q.chip_flag;
  genvar gi;
  generate
    for (gi = 0; gi < `CICOMB_NSRC; gi++) begin : g_det
      cicomb_pulse_det u_det (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .src_in     (src_mix[gi]),
        .pulse_out  (det_pulse[gi]),
        .level_out  (det_level[gi])
      );
    end
  endgenerate
  assign wr_status     = wr_in && (addr_in == `CICOMB_OFS_STATUS);
  assign wr_chipclr    = wr_in && (addr_in == `CICOMB_OFS_CHIPCLR);
  assign clr_mask      = wr_status ? wdata_in[`CICOMB_NSRC-1:0] : '0;
  assign chip_clr_mask = wr_chipclr ? wdata_in[`CICOMB_NSRC-1:0] : '0;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // set wins over software clear; a held level re-sets the flag
    st_d.flag = (st_q.flag & ~clr_mask) | det_pulse;
    st_d.chip_flag = (st_q.chip_flag & ~chip_clr_mask) | chip_signal_set_in;
    if (wr_in) begin
      case (addr_in)
        `CICOMB_OFS_ENABLE:  st_d.enable = wdata_in[`CICOMB_NSRC-1:0];
        `CICOMB_OFS_ROUTE:   st_d.route  = wdata_in[`CICOMB_NSRC-1:0];
        `CICOMB_OFS_VSIZE:   st_d.vsize  = cicomb_vsize_e'(wdata_in[`CICOMB_VSIZE_W-1:0]);
        `CICOMB_OFS_IRQMASK: st_d.imask  = wdata_in[1:0];
        `CICOMB_OFS_CHIPSIG: st_d.chip_flag = st_d.chip_flag | wdata_in[`CICOMB_NSRC-1:0];
        default: ;
      endcase
    end
    // route bit set sends a source to the fast line, clear to the normal line
    st_d.fast_interrupt_request  = |(st_d.flag & st_d.enable & st_d.route);
    st_d.nirq = |(st_d.flag & st_d.enable & ~st_d.route);
    st_d.istat = st_q.istat & ~((wr_in && addr_in == `CICOMB_OFS_IRQSTAT) ? wdata_in[1:0] : 2'h0);
    if (st_d.fast_interrupt_request && !st_q.fast_interrupt_request) begin
      st_d.istat[`CICOMB_IRQ_FIQ_BIT] = 1'b1;
    end
    if (st_d.nirq && !st_q.nirq) begin
      st_d.istat[`CICOMB_IRQ_IRQ_BIT] = 1'b1;
    end
    st_d.rdata = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        `CICOMB_OFS_STATUS:  st_d.rdata = {24'h00_0000, st_q.flag};
        `CICOMB_OFS_ENABLE:  st_d.rdata = {24'h00_0000, st_q.enable};
        `CICOMB_OFS_ROUTE:   st_d.rdata = {24'h00_0000, st_q.route};
        `CICOMB_OFS_VSIZE:   st_d.rdata = {30'h0000_0000, st_q.vsize};
        `CICOMB_OFS_ACTIVE:  st_d.rdata = {24'h00_0000, st_q.flag & st_q.enable};
        `CICOMB_OFS_RAW:     st_d.rdata = {24'h00_0000, det_level};
        `CICOMB_OFS_IRQSTAT: st_d.rdata = {30'h0000_0000, st_q.istat};
        `CICOMB_OFS_IRQMASK: st_d.rdata = {30'h0000_0000, st_q.imask};
        `CICOMB_OFS_CHIPSIG: st_d.rdata = {24'h00_0000, st_q.chip_flag};
        default:             st_d.rdata = 32'h0000_0000;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st_q        <= '0;
      st_q.enable <= `CICOMB_ENABLE_RST;
      st_q.route  <= `CICOMB_ROUTE_RST;
      st_q.vsize  <= cicomb_vsize_e'(`CICOMB_VSIZE_RST);
    end else begin
      st_q <= st_d;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_out                    = st_q.rdata;
  assign fast_interrupt_request_out   = st_q.fast_interrupt_request;
  assign normal_interrupt_request_out = st_q.nirq;
  assign chip_signal_interrupt_out    = st_q.chip_flag;
  assign vector_entry_bytes_out       = 8'h01 << st_q.vsize;
  assign irq_out                      = |(st_q.istat & st_q.imask);
endmodule // cicomb_top
`default_nettype wire

// >>> sim/cicomb_chk.sv
// port assertions of the interrupt combiner
`timescale 1ns/1ps
`default_nettype none
module cicomb_chk (
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic [3:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        fast_interrupt_request_out,
  input wire logic        normal_interrupt_request_out,
  input wire logic [7:0]  chip_signal_interrupt_out,
  input wire logic [7:0]  vector_entry_bytes_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  a_rd_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read slot");
  a_vsize_reset: assert property ($fell(srst_in) |-> vector_entry_bytes_out == 8'h01)
    else $error("entry size after reset");
  a_vsize_write: assert property (wr_in && addr_in == 4'h3 |=>
    vector_entry_bytes_out == (8'h01 << $past(wdata_in[1:0])))
    else $error("entry size after write");
  a_vsize_held: assert property (!$stable(vector_entry_bytes_out) |-> $past(wr_in && addr_in == 4'h3))
    else $error("entry size moved alone");
  a_chip_set: assert property (wr_in && addr_in == 4'h8 |=>
    (chip_signal_interrupt_out & $past(wdata_in[7:0])) == $past(wdata_in[7:0]))
    else $error("chip flag not set");
  a_chip_clear: assert property (wr_in && addr_in == 4'h9 |=>
    (chip_signal_interrupt_out & $past(wdata_in[7:0])) == 8'h00)
    else $error("chip flag not cleared");
  a_fast_fall: assert property ($fell(fast_interrupt_request_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("fast request dropped alone");
  a_norm_fall: assert property ($fell(normal_interrupt_request_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("normal request dropped alone");
endmodule // cicomb_chk
bind cicomb_top cicomb_chk cicomb_chk_i (.*);
`default_nettype wire

// >>> sim/cicomb_cpu_model.sv
// processor core model: counts request entries
`timescale 1ns/1ps
`default_nettype none
module cicomb_cpu_model (
  input  wire logic       ref_clk_in,
  input  wire logic       fast_in,
  input  wire logic       normal_in,
  output logic      [7:0] entries_out
);
  logic f_q = 1'b0;
  logic n_q = 1'b0;
  initial entries_out = 8'h00;
  always @(posedge ref_clk_in) begin
    if ((fast_in && !f_q) || (normal_in && !n_q)) entries_out <= entries_out + 8'h01;
    f_q <= fast_in;
    n_q <= normal_in;
  end
endmodule // cicomb_cpu_model
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench of the interrupt combiner
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; $display("wrong value %0t %h %h", $time, a, b); end end
module testbench;
  logic        ref_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [3:0]  addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [7:0]  sys_int_in = 8'h00;
  logic [7:0]  chip_signal_set_in = 8'h00;
  logic [31:0] rdata_out;
  logic        fast_interrupt_request_out;
  logic        normal_interrupt_request_out;
  logic        irq_out;
  logic [7:0]  chip_signal_interrupt_out;
  logic [7:0]  vector_entry_bytes_out;
  logic [7:0]  seen;
  int          n_errors = 0;
  int          checked = 0;
  int          mflag = 0;
  int          men;
  int          mroute;
  always #2 ref_clk_in = ~ref_clk_in;
  cicomb_top cicomb_top_i (.*);
  cicomb_cpu_model cicomb_cpu_model_i (.ref_clk_in(ref_clk_in), .fast_in(fast_interrupt_request_out),
    .normal_in(normal_interrupt_request_out), .entries_out(seen));
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 `CHK(rdata_out, e)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1630));
    repeat (6) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rd(4'h3, 32'h0);
    `CHK(vector_entry_bytes_out, 8'h01)
    rd(4'hF, 32'h0);
    for (int v = 0; v < 4; v++) begin
      wr(4'h3, v);
      #1 `CHK(vector_entry_bytes_out, 8'h01 << v)
    end
    wr(4'h3, 32'h2);
    $display("test done: entry size");
    for (int t = 0; t < 4; t++) begin
      @(posedge ref_clk_in);
      sys_int_in <= 8'($urandom);
      @(posedge ref_clk_in);
      mflag |= sys_int_in;
      sys_int_in <= 8'h00;
      men = $urandom;
      mroute = $urandom;
      wr(4'h1, men);
      wr(4'h2, mroute);
      repeat (6) @(posedge ref_clk_in);
      rd(4'h0, mflag);
      `CHK(fast_interrupt_request_out, |(mflag & men & mroute & 255))
      `CHK(normal_interrupt_request_out, |(mflag & men & ~mroute & 255))
    end
    wr(4'h0, 32'hFF);
    $display("test done: routing");
    wr(4'h1, 32'hFF);
    wr(4'h2, 32'h0);
    wr(4'h8, 32'h1);
    repeat (6) @(posedge ref_clk_in);
    `CHK(chip_signal_interrupt_out, 8'h01)
    `CHK(normal_interrupt_request_out, 1'b1)
    wr(4'h0, 32'h1);
    repeat (6) @(posedge ref_clk_in);
    rd(4'h0, 32'h1);
    rd(4'h8, 32'h1);
    wr(4'h9, 32'h1);
    repeat (4) @(posedge ref_clk_in);
    wr(4'h0, 32'h1);
    repeat (4) @(posedge ref_clk_in);
    rd(4'h0, 32'h0);
    `CHK(chip_signal_interrupt_out, 8'h00)
    `CHK(normal_interrupt_request_out, 1'b0)
    $display("test done: chip signal");
    `CHK(irq_out, 1'b0)
    wr(4'h7, 32'h2);
    #1 `CHK(irq_out, 1'b1)
    wr(4'h6, 32'h3);
    #1 `CHK(irq_out, 1'b0)
    `CHK(seen != 8'h00, 1'b1)
    @(posedge ref_clk_in);
    chip_signal_set_in <= 8'h02;
    @(posedge ref_clk_in);
    chip_signal_set_in <= 8'h00;
    #1 `CHK(chip_signal_interrupt_out, 8'h02)
    wr(4'h9, 32'h2);
    #1 `CHK(chip_signal_interrupt_out, 8'h00)
    $display("test done: interrupt");
    close_out;
  end
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    n_errors++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
